// ---- core/hpi_bridge_defines.vh ----
// constants and behaviour summary for the pass-thru register read bridge
// What this block does
// - state machine runs on buffered pci clock, 33 MHz max, 30 ns state
// - access select: 00 control, 01 address, 10 data inc, 11 data
// - access select decoded from address latched under address strobe
// - read/write line is the inverted pass-thru write indicator
// - halfword select low for first halfword, high for second
// - address strobe and second data strobe unused, held high
// - host port select asserted from the state after the address strobe through the pass-thru ready state
// - read value goes through the halfword buffer, on pass-thru data a cycle after capture
// - idle waits for attention low on a read and host port region number
// - first state: address strobe low, add-on select and address
// - next: strobe released, add-on write strobe, host select asserted
// - halfword low with access select, then data strobe with lanes 1:0
// - ready synchronised on two flops before sampling, two cycles
// - on ready: strobe off, halfword high, lanes 1:0 to 3:2
// - strobe reasserted for second halfword without checking ready
// - strobe, write strobe, lanes off; pass-thru ready asserted
// - final: selects, address, pass-thru ready released, back to idle
// - pass-thru data register address is 01011 on lines 6:2
// - machine held in reset while buffered pci reset is low
`ifndef HPI_BRIDGE_DEFINES_VH
`define HPI_BRIDGE_DEFINES_VH

`define CLK_PERIOD_NS    30
`define SYNC_STAGES      2
`define PT_DATA_ADDR     5'h0b
`define ACC_SEL_LSB      2
`define ACC_SEL_CONTROL  2'h0
`define ACC_SEL_ADDRESS  2'h1
`define ACC_SEL_DATA_INC 2'h2
`define ACC_SEL_DATA     2'h3
`define ACC_SEL_RESET    2'h3
`define HPI_REGION_DFLT  2'h0
`define BE_LOW_N         4'hc
`define BE_HIGH_N        4'h3
`define BE_NONE_N        4'hf

`endif

// ---- core/hpi_read_bridge.v ----
// pass-thru to host port register read bridge with two-entry halfword buffer
`timescale 1ns/100ps
`default_nettype none
`include "hpi_bridge_defines.vh"

module hpi_read_bridge #(
    parameter [1:0] HPI_REGION = `HPI_REGION_DFLT
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    input  wire        buffered_pci_reset_n,
    // pass-thru indicators
    input  wire        passthru_attention_n,
    input  wire [1:0]  passthru_region_number,
    input  wire        passthru_write_indicator,
    input  wire [15:0] addon_data_in,
    // pass-thru controls
    output reg         address_output_strobe_n,
    output reg         addon_select_n,
    output reg         addon_write_n,
    output reg  [4:0]  addon_address,
    output reg  [3:0]  addon_byte_enable_n,
    output reg         passthru_ready_n,
    output reg  [15:0] addon_data_out,
    output reg         addon_data_oe_n,
    // host port
    input  wire [15:0] host_data_in,
    input  wire        host_ready_n,
    output reg         host_port_select_n,
    output reg         host_data_strobe_n,
    output reg         second_data_strobe_n,
    output reg         host_address_strobe_n,
    output reg         host_read_not_write,
    output reg  [1:0]  host_byte_enable_n,
    output reg         halfword_select,
    output reg  [1:0]  access_select,
    // status
    output reg         busy
);

    localparam [3:0] S_IDLE  = 4'd0;
    localparam [3:0] S_ADDR  = 4'd1;
    localparam [3:0] S_SEL   = 4'd2;
    localparam [3:0] S_SETUP = 4'd3;
    localparam [3:0] S_DS1   = 4'd4;
    localparam [3:0] S_WAIT  = 4'd5;
    localparam [3:0] S_SWAP  = 4'd6;
    localparam [3:0] S_DS2   = 4'd7;
    localparam [3:0] S_DONE  = 4'd8;
    localparam [3:0] S_END   = 4'd9;

    // combined reset: board reset or controller pci reset
    wire       reset_all = rst | ~buffered_pci_reset_n;

    reg  [3:0] state_ff;
    reg  [3:0] nxt_state;
    reg        rdy_meta_ff;
    reg        rdy_sync_ff;
    reg  [1:0] acc_sel_ff;

    // two-entry halfword buffer between host data and pass-thru data
    reg  [15:0] buf_ff [0:1];
    reg         wr_ptr_ff;
    reg         rd_ptr_ff;
    reg  [1:0]  count_ff;
    wire        buf_in_ready  = (count_ff != 2'd2);
    wire        buf_out_valid = (count_ff != 2'd0);
    wire        buf_in_valid;
    wire        buf_out_ready;

    // host port data is captured at the end of each data strobe
    assign buf_in_valid  = (state_ff == S_WAIT && !rdy_sync_ff) ||
                           (state_ff == S_DS2);
    assign buf_out_ready = 1'b1; // controller register always takes a word

    // ready synchroniser; only the second flop is sampled
    // both flops read not-ready outside the wait state, so a ready level
    // left over from before the data strobe cannot end the wait early
    always @(posedge clk) begin
        if (reset_all) begin
            rdy_meta_ff <= 1'b1;
            rdy_sync_ff <= 1'b1;
        end else if (state_ff != S_WAIT) begin
            rdy_meta_ff <= 1'b1;
            rdy_sync_ff <= 1'b1;
        end else begin
            rdy_meta_ff <= host_ready_n;
            rdy_sync_ff <= rdy_meta_ff;
        end
    end

    // next-state decision
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (!passthru_attention_n &&
                    passthru_region_number == HPI_REGION &&
                    !passthru_write_indicator)
                    nxt_state = S_ADDR;
            end
            S_ADDR:  nxt_state = S_SEL;
            S_SEL:   nxt_state = S_SETUP;
            S_SETUP: nxt_state = S_DS1;
            S_DS1:   nxt_state = S_WAIT;
            S_WAIT: begin
                // stall while the buffer is full so no halfword is lost
                if (!rdy_sync_ff && buf_in_ready)
                    nxt_state = S_SWAP;
            end
            S_SWAP:  nxt_state = S_DS2;
            S_DS2: begin
                if (buf_in_ready)
                    nxt_state = S_DONE;
            end
            S_DONE:  nxt_state = S_END;
            S_END:   nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    // state register
    always @(posedge clk) begin
        if (reset_all)
            state_ff <= S_IDLE;
        else
            state_ff <= nxt_state;
    end

    // access select latched while the address strobe is low
    always @(posedge clk) begin
        if (reset_all)
            acc_sel_ff <= `ACC_SEL_RESET;
        else if (state_ff == S_ADDR)
            acc_sel_ff <= addon_data_in[`ACC_SEL_LSB+1:`ACC_SEL_LSB];
    end

    // halfword buffer storage
    always @(posedge clk) begin
        if (reset_all) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'd0;
        end else begin
            if (buf_in_valid && buf_in_ready) begin
                buf_ff[wr_ptr_ff] <= host_data_in;
                wr_ptr_ff         <= ~wr_ptr_ff;
            end
            if (buf_out_valid && buf_out_ready)
                rd_ptr_ff <= ~rd_ptr_ff;
            count_ff <= count_ff
                      + {1'b0, buf_in_valid && buf_in_ready}
                      - {1'b0, buf_out_valid && buf_out_ready};
        end
    end

    // pass-thru data output from the buffer head
    always @(posedge clk) begin
        if (reset_all) begin
            addon_data_out  <= 16'h0000;
            addon_data_oe_n <= 1'b1;
        end else begin
            if (buf_out_valid)
                addon_data_out <= buf_ff[rd_ptr_ff];
            // drive only in the cycle after a word left the buffer,
            // so each driven cycle carries one fresh halfword
            addon_data_oe_n <= !(buf_out_valid && buf_out_ready);
        end
    end

    // registered control outputs follow the next state
    always @(posedge clk) begin
        if (reset_all) begin
            address_output_strobe_n <= 1'b1;
            addon_select_n          <= 1'b1;
            addon_write_n           <= 1'b1;
            addon_address           <= 5'h00;
            addon_byte_enable_n     <= `BE_NONE_N;
            passthru_ready_n        <= 1'b1;
            host_port_select_n      <= 1'b1;
            host_data_strobe_n      <= 1'b1;
            halfword_select         <= 1'b0;
            access_select           <= `ACC_SEL_RESET;
            busy                    <= 1'b0;
        end else begin
            busy <= (nxt_state != S_IDLE);
            // address phase and add-on selection
            address_output_strobe_n <= !(nxt_state == S_ADDR);
            addon_select_n <= !(nxt_state != S_IDLE &&
                                nxt_state != S_END);
            addon_address  <= (nxt_state != S_IDLE && nxt_state != S_END) ?
                              `PT_DATA_ADDR : 5'h00;
            // add-on write strobe spans both halfwords
            addon_write_n <= !(nxt_state >= S_SEL &&
                               nxt_state <= S_DS2);
            // host port select over the transfer
            host_port_select_n <= !(nxt_state >= S_SEL &&
                                    nxt_state <= S_DONE);
            // data strobe for each halfword
            host_data_strobe_n <= !(nxt_state == S_DS1 ||
                                    nxt_state == S_WAIT ||
                                    nxt_state == S_DS2);
            // halfword select: low first, high second
            halfword_select <= (nxt_state == S_SWAP ||
                                nxt_state == S_DS2);
            if (nxt_state == S_SETUP)
                access_select <= acc_sel_ff;
            // byte lane steering into the pass-thru register
            if (nxt_state == S_DS1 || nxt_state == S_WAIT)
                addon_byte_enable_n <= `BE_LOW_N;
            else if (nxt_state == S_SWAP || nxt_state == S_DS2)
                addon_byte_enable_n <= `BE_HIGH_N;
            else
                addon_byte_enable_n <= `BE_NONE_N;
            passthru_ready_n <= !(nxt_state == S_DONE);
        end
    end

    // fixed and directly derived host port controls
    always @(posedge clk) begin
        if (reset_all) begin
            second_data_strobe_n  <= 1'b1;
            host_address_strobe_n <= 1'b1;
            host_read_not_write   <= 1'b1;
            host_byte_enable_n    <= 2'h3;
        end else begin
            second_data_strobe_n  <= 1'b1;
            host_address_strobe_n <= 1'b1;
            // registered copy of the inverted write indicator (adds a cycle)
            host_read_not_write   <= ~passthru_write_indicator;
            // enables are ignored on reads, left inactive
            host_byte_enable_n    <= 2'h3;
        end
    end

endmodule // hpi_read_bridge

`default_nettype wire

// ---- tb/hpi_host_model.sv ----
// behavioural host port that answers the bridge's strobes
`timescale 1ns/100ps
`default_nettype none
module hpi_host_model (
    // bridge controls
    input  wire logic        clk,
    input  wire logic        sel_n,
    input  wire logic        ds_n,
    input  wire logic        hw,
    input  wire logic [1:0]  acc,
    input  wire logic [3:0]  delay,
    // answers
    output logic             ready_n,
    output logic [15:0]      data
);
    logic [3:0] cnt = 4'h0;
    // only the first strobe fetches; the second halfword is already there
    always @(negedge ds_n) begin
        if (!sel_n && !hw) begin
            cnt = delay;
        end
    end
    // fetch time runs down on the bridge clock
    always @(posedge clk) begin
        if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
    assign ready_n = (cnt != 4'h0);
    // word marks code and half; inverted when not strobed, byte enables unused
    assign data = {acc, hw, 13'h0a5c} ^ {16{ds_n}};
endmodule // hpi_host_model
`default_nettype wire

// ---- tb/hpi_read_bridge_checker.sv ----
// port assertions for the read bridge
`timescale 1ns/100ps
`default_nettype none
module hpi_read_bridge_checker (
    // clock, reset and inputs
    input wire logic clk, rst, buffered_pci_reset_n, host_ready_n,
    input wire logic passthru_write_indicator, busy,
    // pass-thru side
    input wire logic address_output_strobe_n, addon_select_n, addon_write_n,
    input wire logic passthru_ready_n,
    input wire logic [4:0] addon_address,
    input wire logic [3:0] addon_byte_enable_n,
    // host port side
    input wire logic host_port_select_n, host_data_strobe_n, halfword_select,
    input wire logic second_data_strobe_n, host_address_strobe_n,
    input wire logic host_read_not_write,
    input wire logic [1:0] host_byte_enable_n,
    input wire logic [1:0] access_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !buffered_pci_reset_n);
    strobe_pulse_a: assert property (!address_output_strobe_n |->
        !addon_select_n && addon_address == 5'h0b ##1 address_output_strobe_n)
        else $error("address strobe phase wrong");
    write_phase_a: assert property ($rose(address_output_strobe_n) |->
        !addon_write_n && !host_port_select_n) else $error("write phase late");
    rnw_follow_a: assert property (!$past(rst) && $past(buffered_pci_reset_n) |->
        host_read_not_write == !$past(passthru_write_indicator))
        else $error("read/write line wrong");
    unused_high_a: assert property (second_data_strobe_n &&
        host_address_strobe_n) else $error("unused strobe driven");
    select_span_a: assert property (!host_data_strobe_n |->
        !host_port_select_n && !addon_select_n) else $error("strobe unselected");
    acc_hold_a: assert property (!host_data_strobe_n |->
        $stable(access_select)) else $error("access select moved");
    first_lanes_a: assert property ($fell(host_data_strobe_n) &&
        !halfword_select |-> addon_byte_enable_n == 4'hc) else $error("lanes");
    sync_wait_a: assert property ($rose(halfword_select) |->
        $past(host_ready_n) == 1'b0 && $past(host_ready_n, 2) == 1'b0)
        else $error("ready not synchronised");
    swap_a: assert property ($rose(halfword_select) |-> host_data_strobe_n &&
        addon_byte_enable_n == 4'h3 ##1 !host_data_strobe_n) else $error("swap");
    ready_end_a: assert property (!passthru_ready_n |-> addon_write_n &&
        addon_byte_enable_n == 4'hf ##1 passthru_ready_n && addon_select_n &&
        host_port_select_n && addon_address == 5'h00) else $error("ending");
    pci_reset_a: assert property (disable iff (rst) !buffered_pci_reset_n |=>
        !busy && host_port_select_n) else $error("not held in reset");
endmodule // hpi_read_bridge_checker
bind hpi_read_bridge hpi_read_bridge_checker i_chk (.*);
`default_nettype wire

// ---- tb/hpi_read_bridge_test.sv ----
// self-checking bench for the pass-thru register read bridge
`timescale 1ns/100ps
`default_nettype none
module hpi_read_bridge_test;
    logic clk = 1'b0, rst = 1'b1, buffered_pci_reset_n = 1'b1;
    logic passthru_attention_n = 1'b1, passthru_write_indicator = 1'b0;
    logic [1:0] passthru_region_number = 2'h0, acc_c = 2'h0, last_acc = 2'h3;
    logic [3:0] dly = 4'h1;
    logic [15:0] addon_data_in, host_data_in, addon_data_out;
    logic host_ready_n, address_output_strobe_n, addon_select_n, addon_write_n;
    logic passthru_ready_n, addon_data_oe_n, host_port_select_n, busy;
    logic host_data_strobe_n, second_data_strobe_n, host_address_strobe_n;
    logic host_read_not_write, halfword_select;
    logic [4:0] addon_address;
    logic [3:0] addon_byte_enable_n;
    logic [1:0] host_byte_enable_n, access_select;
    logic [15:0] q[$];
    int errors = 0, n_tests = 0, cycles = 0;
    // rows: code, write, region, fetch delay, served
    logic [9:0] rows [6] = '{{2'h0,1'b0,2'h0,4'h1,1'b1}, {2'h1,1'b0,2'h0,4'h3,1'b1},
        {2'h2,1'b0,2'h0,4'h1,1'b1}, {2'h3,1'b0,2'h0,4'h6,1'b1},
        {2'h3,1'b1,2'h0,4'h1,1'b0}, {2'h1,1'b0,2'h2,4'h1,1'b0}};
    always #2.5 clk = ~clk;
    // controller shows the target code only under the address strobe
    assign addon_data_in = {12'h000, acc_c, 2'h0} ^ {16{address_output_strobe_n}};
    hpi_read_bridge i_dut (.*);
    hpi_host_model i_host (.clk(clk), .sel_n(host_port_select_n),
        .ds_n(host_data_strobe_n), .hw(halfword_select), .acc(access_select),
        .delay(dly), .ready_n(host_ready_n), .data(host_data_in));
    // collect halfwords leaving the buffer; a hang ends the run
    always @(posedge clk) begin
        if (addon_data_oe_n === 1'b0) q.push_back(addon_data_out);
        cycles++;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task idle_check();
        check({host_port_select_n, addon_select_n, busy, access_select,
            addon_byte_enable_n}, {3'b110, last_acc, 4'hf});
    endtask
    task run(input logic [9:0] r);
        int k;
        k = 0;
        q.delete();
        {acc_c, passthru_write_indicator, passthru_region_number, dly} = r[9:1];
        passthru_attention_n = 1'b0;
        while (passthru_ready_n !== 1'b0 && k < 40) begin
            @(negedge clk);
            k++;
        end
        passthru_attention_n = 1'b1;
        repeat (4) @(negedge clk);
        check(k < 40, r[0]);
        check(host_read_not_write, !passthru_write_indicator);
        if (r[0]) begin
            last_acc = acc_c;
            check(k >= 8, 1'b1);
            check({q[1], q[0]}, {acc_c, 14'h2a5c, acc_c, 14'h0a5c});
        end
        idle_check();
    endtask
    task report_and_stop();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        idle_check();
        foreach (rows[i]) run(rows[i]);
        // controller reset in mid-fetch, then a clean transfer again
        {acc_c, passthru_write_indicator, passthru_region_number} = 5'h08;
        dly = 4'hc;
        passthru_attention_n = 1'b0;
        repeat (7) @(negedge clk);
        buffered_pci_reset_n = 1'b0;
        passthru_attention_n = 1'b1;
        repeat (2) @(negedge clk);
        last_acc = 2'h3;
        idle_check();
        buffered_pci_reset_n = 1'b1;
        repeat (12) @(negedge clk);
        run(rows[1]);
        report_and_stop();
    end
endmodule // hpi_read_bridge_test
`default_nettype wire
